// >>> dv/ccsr_ctx_engine_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module ccsr_ctx_engine_test;
    import ccsr_pkg::*;
    localparam int RAM_WORDS = 512;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hwrite = 1'h0;
    logic rd_dp = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, ram_rdata;
    logic hreadyout, hresp, ctx_busy, run_ok, err_exit, ram_ack;
    logic [15:0] start_pc;
    logic [7:0] current_priority_field;
    ccsr_core_req_s core = '0;
    ccsr_ram_req_s ram;
    logic [47:0] exp_q[$];
    logic [47:0] ev;
    logic [31:0] g[8];
    int mismatches = 0;
    int tests_run = 0;

    // ----
    // harness
    // ----
    ccsr_ctx_engine #(.RAM_WORDS(RAM_WORDS)) ccsr_ctx_engine_i (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'h1), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core(core), .ctx_busy(ctx_busy), .run_ok(run_ok),
        .err_exit(err_exit), .start_pc(start_pc), .current_priority_field(current_priority_field),
        .ram(ram), .ram_ack(ram_ack), .ram_rdata(ram_rdata));
    ccsr_ram_model #(.WORDS(RAM_WORDS)) ccsr_ram_model_i (
        .hclk(hclk), .hresetn(hresetn), .ram(ram), .ram_ack(ram_ack), .ram_rdata(ram_rdata));

    initial begin
        forever #25 hclk = ~hclk;
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= CCSR_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd_dp <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back({16'h0, x});
        bus(1'h0, a, 32'h0);
    endtask

    task automatic pulse(input logic term, input int p);
        @(posedge hclk);
        core.term <= term;
        core.start <= !term;
        core.prio <= 8'(p);
        @(posedge hclk);
        core.term <= 1'h0;
        core.start <= 1'h0;
    endtask

    task automatic wait_for(input logic idle);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (n < 300 && (idle ? ctx_busy !== 1'h0 : run_ok !== 1'h1 && err_exit !== 1'h1));
        if (n >= 300) mismatches++;
    endtask

    function automatic logic [47:0] nxt();
        if (exp_q.size() == 0) return 'x;
        return exp_q.pop_front();
    endfunction

    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge hclk) begin
        if (rd_dp && hreadyout) begin
            ev = nxt();
            `CHK("hrdata", ev, {16'h0, hrdata})
            `CHK("hresp", 1'h0, hresp)
        end
        if (run_ok === 1'h1) begin
            ev = nxt();
            `CHK("start", ev, {24'h0, current_priority_field, start_pc})
        end
        if (err_exit === 1'h1) begin
            ev = nxt();
            `CHK("error", ev, 48'h1)
        end
        if (ram.req && ram.we && ram_ack) begin
            ev = nxt();
            `CHK("save", ev, {2'h0, ram.addr, ram.wdata})
        end
    end

    initial begin
        int p, sz, fst, b;
        logic [15:0] pc;
        logic [31:0] w6, w7;
        void'($urandom(99));
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        rd(CCSR_OFS_CTRL, 32'h0);
        rd(CCSR_OFS_STATUS, 32'h0);
        rd(8'h1C, 32'h0);
        for (int m = 0; m < 3; m++) begin
            for (int sm = 0; sm < 2; sm++) begin
                sz = 8 >> m;
                fst = 8 - sz;
                p = 1 + $urandom % 40;
                b = p * sz;
                bus(1'h1, CCSR_OFS_CTRL, {29'h1, 1'(sm), 2'(m)});
                for (int n = 0; n < 8; n++) begin
                    g[n] = $urandom;
                    bus(1'h1, CCSR_OFS_GPR0 + 8'(4 * n), g[n]);
                end
                w6 = ccsr_ram_model_i.mem[b + 6 - fst];
                w7 = ccsr_ram_model_i.mem[b + 7 - fst];
                exp_q.push_back({24'h0, w6[31:24], sm ? 16'(2 * p) : w7[31:16]});
                pulse(1'h0, p);
                wait_for(1'h0);
                for (int n = 0; n < 8; n++) begin
                    rd(CCSR_OFS_GPR0 + 8'(4 * n), n < fst ? g[n] : n == 7 ? {16'h0, w7[15:0]}
                        : ccsr_ram_model_i.mem[b + n - fst]);
                end
                rd(CCSR_OFS_ICTRL, {24'h0, w6[31:24]});
                pc = 16'($urandom);
                core.pc <= pc;
                for (int n = 0; n < 8; n++) begin
                    g[n] = $urandom;
                    bus(1'h1, CCSR_OFS_GPR0 + 8'(4 * n), g[n]);
                    if (n >= fst) exp_q.push_back({2'h0, 14'(b + n - fst), n == 7 ? {pc, g[n][15:0]} : g[n]});
                end
                pulse(1'h1, 0);
                wait_for(1'h1);
                `CHK("drain", 0, exp_q.size())
            end
        end
        bus(1'h1, CCSR_OFS_CTRL, 32'h8);
        exp_q.push_back(48'h1);
        pulse(1'h0, RAM_WORDS / 8);
        wait_for(1'h0);
        rd(CCSR_OFS_STATUS, 32'h4);
        bus(1'h1, CCSR_OFS_STATUS, 32'h4);
        rd(CCSR_OFS_STATUS, 32'h0);
        finish_test();
    end

    // whole run needs under a thousand cycles; this only cuts a hang
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        finish_test();
    end
endmodule

bind ccsr_ctx_engine ccsr_ctx_monitor #(.RAM_WORDS(RAM_WORDS)) ccsr_ctx_monitor_i (
    .hclk(hclk), .hresetn(hresetn), .ctx_busy(ctx_busy), .run_ok(run_ok), .err_exit(err_exit),
    .ram(ram), .ram_ack(ram_ack));

// >>> dv/ccsr_ctx_monitor.sv
`timescale 1ns/100ps
module ccsr_ctx_monitor
    import ccsr_pkg::*;
#(
    parameter int RAM_WORDS = 512
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // engine outputs and ram acknowledge
    input wire logic ctx_busy,
    input wire logic run_ok,
    input wire logic err_exit,
    input wire ccsr_pkg::ccsr_ram_req_s ram,
    input wire logic ram_ack
);
    // ----
    // context engine checks
    // ----
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_RAM_HOLD:
    assert property (ram.req && !ram_ack |=> ram.req && $stable(ram.addr) && $stable(ram.we)
        && (!ram.we || $stable(ram.wdata))) else $error("ram word changed before ack");
    AST_RAM_BUSY:
    assert property (ram.req |-> ctx_busy) else $error("ram access while idle");
    AST_WORD_STEP:
    assert property (ram.req && ram_ack ##1 ram.req |-> ram.addr == $past(ram.addr) + 14'h1)
        else $error("context words not contiguous");
    AST_REGION_ZERO:
    assert property (ram.req |-> ram.addr >= 14'h2) else $error("region zero accessed");
    AST_RAM_RANGE:
    assert property (ram.req |-> ram.addr < RAM_WORDS) else $error("access beyond ram");
    AST_ERR_ALONE:
    assert property (err_exit |-> !run_ok && !ram.req ##1 !err_exit) else $error("error exit malformed");
    AST_RUN_PULSE:
    assert property (run_ok |-> !ram.req ##1 !run_ok) else $error("run start while ram busy");
    AST_RUN_AFTER_ACK:
    assert property ($rose(run_ok) |-> $past(ctx_busy)) else $error("run start without restore");

    cover property (run_ok);
    cover property (err_exit);
    cover property (ram.req && ram.we && ram_ack);
endmodule

// >>> dv/ccsr_ram_model.sv
`timescale 1ns/100ps
module ccsr_ram_model
    import ccsr_pkg::*;
#(
    parameter int WORDS = 512
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // word port
    input wire ccsr_pkg::ccsr_ram_req_s ram,
    output logic ram_ack,
    output logic [ccsr_pkg::CCSR_DW-1:0] ram_rdata
);
    // ----
    // parameter ram
    // ----
    logic [31:0] mem [WORDS];
    int dly_r;

    initial begin
        for (int i = 0; i < WORDS; i++) begin
            mem[i] = 32'h9E37_79B9 * (i + 1);
        end
    end

    // random wait states; read data scrambled outside the ack cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ram_ack <= 1'h0;
            ram_rdata <= 32'h0;
            dly_r <= 0;
        end else if (ram.req && !ram_ack && dly_r == 0) begin
            ram_ack <= 1'h1;
            ram_rdata <= mem[ram.addr];
            if (ram.we) mem[ram.addr] <= ram.wdata;
            dly_r <= $urandom % 4;
        end else begin
            ram_ack <= 1'h0;
            ram_rdata <= ~ram_rdata;
            if (ram.req && dly_r > 0) dly_r <= dly_r - 1;
        end
    end
endmodule

// >>> src/ccsr_addr_gen.sv
`timescale 1ns/100ps
module ccsr_addr_gen
    import ccsr_pkg::*;
#(
    parameter int AW = ccsr_pkg::CCSR_AW
) (
    // selection
    input wire logic [1:0] model,
    input wire logic [ccsr_pkg::CCSR_PNW-1:0] prio,
    input wire logic [2:0] reg_idx,
    // result
    output logic [AW-1:0] addr,
    output logic [2:0] first_reg,
    output logic [AW:0] region_end
);
    logic [3:0] size;
    logic [AW:0] base;

    always_comb begin
        unique case (model)
            CCSR_CM_SMALL: begin
                size = CCSR_SZ_SMALL;
                first_reg = CCSR_FIRST_SMALL;
            end
            CCSR_CM_MIN: begin
                size = CCSR_SZ_MIN;
                first_reg = CCSR_FIRST_MIN;
            end
            default: begin
                size = CCSR_SZ_FULL;
                first_reg = CCSR_FIRST_FULL;
            end
        endcase
    end

    // R8 region base is priority times size; R9 area starts at zero
    assign base = (AW+1)'(prio) * (AW+1)'(size);
    assign region_end = base + (AW+1)'(size);
    assign addr = AW'(base + (AW+1)'(reg_idx - first_reg));
endmodule

// >>> src/ccsr_ctx_engine.sv
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
// Notes on behaviour
// R1: on termination save model registers; on next activation restore them.
// R2: request priority number selects both program and context region.
// R3: full model moves registers zero to seven, eight words.
// R4: small model moves registers four to seven only.
// R5: minimum model moves registers six and seven only.
// R6: one global model select applies to all channels.
// R7: software sets model only before running; changing it corrupts restores.
// R8: region word address equals priority times context size.
// R9: save area starts at word zero, equal regions upward.
// R10: priority zero is invalid; region zero never holds a context.
// R11: requesters never send priorities whose region exceeds parameter ram.
// R12: with range check on, out-of-ram region forces error exit.
// R13: save writes low half of register seven and pc above it.
// R14: restore loads low half of word seven into register seven.
// R15: resume mode loads pc from upper half of word seven.
// R16: restart mode derives pc from priority, discards upper half.
// R17: restore loads word six whole and copies top byte to priority.
// R18: registers outside the model are left untouched.
// R19: host preloads each channel context before starting.
// R20: start mode select one means restart, zero means resume.
// R21: restart pc equals twice the request priority number.
// R22: save completes before restore; restore completes before execution.
module ccsr_ctx_engine
    import ccsr_pkg::*;
#(
    parameter int RAM_WORDS = 512
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core side
    input wire ccsr_pkg::ccsr_core_req_s core,
    output logic ctx_busy,
    output logic run_ok,
    output logic err_exit,
    output logic [ccsr_pkg::CCSR_PCW-1:0] start_pc,
    output logic [ccsr_pkg::CCSR_PNW-1:0] current_priority_field,
    // parameter ram port
    output ccsr_pkg::ccsr_ram_req_s ram,
    input wire logic ram_ack,
    input wire logic [ccsr_pkg::CCSR_DW-1:0] ram_rdata
);
    import ccsr_pkg::*;

    typedef enum logic [2:0] {
        CCSR_IDLE,
        CCSR_SAVE,
        CCSR_CHECK,
        CCSR_REST,
        CCSR_RUN
    } ccsr_state_e;

    ccsr_state_e state_r;
    logic [31:0] ctrl_r;
    logic [CCSR_DW-1:0] gpr_r [CCSR_NREG];
    logic [2:0] idx_r;
    logic [CCSR_PNW-1:0] prio_r;
    logic [CCSR_PNW-1:0] next_prio_r;
    logic next_pend_r;
    logic [CCSR_PCW-1:0] pc_r;
    logic [CCSR_PCW-1:0] start_pc_r;
    logic [CCSR_PNW-1:0] cur_prio_r;
    logic err_r;
    logic err_sticky_r;
    logic run_r;

    logic [1:0] model;
    logic start_mode_select;
    logic range_check;
    logic [CCSR_AW-1:0] word_addr;
    logic [2:0] first_reg;
    logic [CCSR_AW:0] region_end;
    logic [CCSR_PNW-1:0] sel_prio;

    // bus side state
    logic dp_valid_r;
    logic dp_write_r;
    logic [7:0] dp_addr_r;
    logic bus_take;

    // R6 one global model for every channel
    assign model = ctrl_r[CCSR_CTRL_CM_LSB +: 2];
    // R20 one selects restart
    assign start_mode_select = ctrl_r[CCSR_CTRL_SM_BIT];
    assign range_check = ctrl_r[CCSR_CTRL_RC_BIT];
    // R2 region follows the live priority
    assign sel_prio = (state_r == CCSR_SAVE) ? prio_r : next_prio_r;

    ccsr_addr_gen #(
        .AW(CCSR_AW)
    ) ccsr_addr_gen_i (
        .model(model),
        .prio(sel_prio),
        .reg_idx(idx_r),
        .addr(word_addr),
        .first_reg(first_reg),
        .region_end(region_end)
    );

    // ------------------------------------------------------------
    // context sequencer
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= CCSR_IDLE;
            idx_r <= 3'h0;
            prio_r <= '0;
            next_pend_r <= 1'b0;
            next_prio_r <= '0;
            err_r <= 1'b0;
        end else if (clk_en) begin
            err_r <= 1'b0;
            // one pending slot only: a second request while one waits is dropped,
            // the arbiter keeps raising it until taken
            // R10 priority zero is never accepted
            if (core.start && core.prio != '0 && !next_pend_r) begin
                next_pend_r <= 1'b1;
                next_prio_r <= core.prio;
            end
            unique case (state_r)
                CCSR_IDLE: begin
                    if (next_pend_r) begin
                        state_r <= CCSR_CHECK;
                    end
                end
                CCSR_RUN: begin
                    // R1 termination triggers the save
                    if (core.term) begin
                        state_r <= CCSR_SAVE;
                        idx_r <= first_reg;
                    end
                end
                CCSR_SAVE: begin
                    if (ram_ack) begin
                        idx_r <= idx_r + 3'h1;
                        // R22 save finishes before any restore
                        if (idx_r == CCSR_REG_SEVEN) begin
                            state_r <= CCSR_IDLE;
                        end
                    end
                end
                CCSR_CHECK: begin
                    // R12 region past ram gives an error exit
                    if (range_check && region_end > (CCSR_AW+1)'(RAM_WORDS)) begin
                        err_r <= 1'b1;
                        next_pend_r <= 1'b0;
                        state_r <= CCSR_IDLE;
                    end else begin
                        state_r <= CCSR_REST;
                        idx_r <= first_reg;
                        prio_r <= next_prio_r;
                    end
                end
                CCSR_REST: begin
                    if (ram_ack) begin
                        idx_r <= idx_r + 3'h1;
                        // R22 restore completes before execution
                        if (idx_r == CCSR_REG_SEVEN) begin
                            state_r <= CCSR_RUN;
                            next_pend_r <= 1'b0;
                        end
                    end
                end
                default: state_r <= CCSR_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // general purpose registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CCSR_NREG; i++) begin
                gpr_r[i] <= '0;
            end
        end else if (clk_en) begin
            if (state_r == CCSR_REST && ram_ack) begin
                // R3 R4 R5 R18 only model registers move
                if (idx_r == CCSR_REG_SEVEN) begin
                    // R14 low half only, upper reads zero
                    gpr_r[idx_r] <= {{CCSR_HALF{1'b0}}, ram_rdata[CCSR_HALF-1:0]};
                end else begin
                    // R17 word six restored whole
                    gpr_r[idx_r] <= ram_rdata;
                end
            end else if (bus_take && dp_write_r && state_r != CCSR_REST) begin
                for (int i = 0; i < CCSR_NREG; i++) begin
                    if (dp_addr_r == CCSR_OFS_GPR0 + 8'(i * 4)) begin
                        gpr_r[i] <= (3'(i) == CCSR_REG_SEVEN)
                            ? {{CCSR_HALF{1'b0}}, hwdata[CCSR_HALF-1:0]} : hwdata;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // channel program counter
    // ------------------------------------------------------------
    // kept apart from the register file so that tracking the live pc
    // never blocks a bus write to a general purpose register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_r <= '0;
        end else if (clk_en) begin
            if (state_r == CCSR_REST && ram_ack && idx_r == CCSR_REG_SEVEN) begin
                // R15 R16 R21 start pc by mode
                pc_r <= start_mode_select
                    ? CCSR_PCW'({next_prio_r, 1'b0})
                    : ram_rdata[CCSR_DW-1:CCSR_HALF];
            end else if (state_r == CCSR_RUN) begin
                // follows the core; the value at termination is what gets saved
                pc_r <= core.pc;
            end
        end
    end

    // ------------------------------------------------------------
    // priority, start pc and status
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_prio_r <= '0;
            start_pc_r <= '0;
            run_r <= 1'b0;
            err_sticky_r <= 1'b0;
        end else if (clk_en) begin
            run_r <= 1'b0;
            if (state_r == CCSR_REST && ram_ack && idx_r == CCSR_REG_SIX) begin
                // R17 top byte of word six to priority
                cur_prio_r <= ram_rdata[CCSR_DW-1:CCSR_PRIO_LSB];
            end
            if (state_r == CCSR_REST && ram_ack && idx_r == CCSR_REG_SEVEN) begin
                start_pc_r <= start_mode_select
                    ? CCSR_PCW'({next_prio_r, 1'b0})
                    : ram_rdata[CCSR_DW-1:CCSR_HALF];
                run_r <= 1'b1;
            end
            // set wins over software clear
            if (err_r) begin
                err_sticky_r <= 1'b1;
            end else if (bus_take && dp_write_r && dp_addr_r == CCSR_OFS_STATUS
                         && hwdata[CCSR_ST_ERR_BIT]) begin
                err_sticky_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // parameter ram port
    // ------------------------------------------------------------
    always_comb begin
        ram.req = (state_r == CCSR_SAVE) || (state_r == CCSR_REST);
        ram.we = (state_r == CCSR_SAVE);
        ram.addr = word_addr;
        // write data follows the index directly, no staging register needed
        // since the word is held until acknowledged unless the host writes that register during save
        // R13 word seven packs pc above low half
        if (idx_r == CCSR_REG_SEVEN) begin
            ram.wdata = {pc_r, gpr_r[idx_r][CCSR_HALF-1:0]};
        end else begin
            ram.wdata = gpr_r[idx_r];
        end
    end

    assign ctx_busy = (state_r != CCSR_RUN) && (state_r != CCSR_IDLE);
    assign run_ok = run_r;
    assign err_exit = err_r;
    assign start_pc = start_pc_r;
    assign current_priority_field = cur_prio_r;

    // ------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ------------------------------------------------------------
    // hsize not decoded: only whole-word transfers are supported
    assign bus_take = dp_valid_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= '0;
        end else if (clk_en) begin
            if (hready) begin
                dp_valid_r <= hsel && htrans == CCSR_HTRANS_NONSEQ;
                dp_write_r <= hwrite;
                dp_addr_r <= haddr[7:0];
            end
        end
    end

    // model change is not blocked in hardware; keeping it fixed while
    // running is left to software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CCSR_CTRL_RST;
        end else if (clk_en) begin
            if (bus_take && dp_write_r && dp_addr_r == CCSR_OFS_CTRL) begin
                ctrl_r <= {28'h0000000, hwdata[3:0]};
            end
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (dp_valid_r && !dp_write_r) begin
            if (dp_addr_r == CCSR_OFS_CTRL) begin
                hrdata = ctrl_r;
            end else if (dp_addr_r == CCSR_OFS_STATUS) begin
                hrdata[CCSR_ST_BUSY_BIT] = ctx_busy;
                hrdata[CCSR_ST_RUN_BIT] = (state_r == CCSR_RUN);
                hrdata[CCSR_ST_ERR_BIT] = err_sticky_r;
            end else if (dp_addr_r == CCSR_OFS_ICTRL) begin
                hrdata[CCSR_PNW-1:0] = cur_prio_r;
            end else begin
                for (int i = 0; i < CCSR_NREG; i++) begin
                    if (dp_addr_r == CCSR_OFS_GPR0 + 8'(i * 4)) begin
                        hrdata = gpr_r[i];
                    end
                end
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule

// >>> src/ccsr_pkg.sv
package ccsr_pkg;

    localparam int CCSR_NREG = 8;
    localparam int CCSR_DW = 32;
    localparam int CCSR_PCW = 16;
    localparam int CCSR_PNW = 8;
    localparam int CCSR_AW = 14;

    // context model encodings
    localparam logic [1:0] CCSR_CM_FULL = 2'h0;
    localparam logic [1:0] CCSR_CM_SMALL = 2'h1;
    localparam logic [1:0] CCSR_CM_MIN = 2'h2;

    // words per context per model
    localparam logic [3:0] CCSR_SZ_FULL = 4'h8;
    localparam logic [3:0] CCSR_SZ_SMALL = 4'h4;
    localparam logic [3:0] CCSR_SZ_MIN = 4'h2;

    // first register saved per model
    localparam logic [2:0] CCSR_FIRST_FULL = 3'h0;
    localparam logic [2:0] CCSR_FIRST_SMALL = 3'h4;
    localparam logic [2:0] CCSR_FIRST_MIN = 3'h6;

    localparam logic [2:0] CCSR_REG_SIX = 3'h6;
    localparam logic [2:0] CCSR_REG_SEVEN = 3'h7;
    localparam int CCSR_PRIO_LSB = 24;
    localparam int CCSR_HALF = 16;

    // register offsets (byte addresses)
    localparam logic [7:0] CCSR_OFS_CTRL = 8'h00;
    localparam logic [7:0] CCSR_OFS_STATUS = 8'h04;
    localparam logic [7:0] CCSR_OFS_ICTRL = 8'h08;
    localparam logic [7:0] CCSR_OFS_GPR0 = 8'h20;

    // control register fields
    localparam int CCSR_CTRL_CM_LSB = 0;
    localparam int CCSR_CTRL_SM_BIT = 2;
    localparam int CCSR_CTRL_RC_BIT = 3;
    localparam logic [31:0] CCSR_CTRL_RST = 32'h0000_0000;

    // status fields
    localparam int CCSR_ST_BUSY_BIT = 0;
    localparam int CCSR_ST_RUN_BIT = 1;
    localparam int CCSR_ST_ERR_BIT = 2;

    localparam logic [1:0] CCSR_HTRANS_NONSEQ = 2'h2;

    typedef enum logic {
        CCSR_DIR_SAVE,
        CCSR_DIR_RESTORE
    } ccsr_dir_e;

    // parameter ram access port
    typedef struct packed {
        logic req;
        logic we;
        logic [CCSR_AW-1:0] addr;
        logic [CCSR_DW-1:0] wdata;
    } ccsr_ram_req_s;

    // core handshake toward this block
    typedef struct packed {
        logic term;
        logic start;
        logic [CCSR_PNW-1:0] prio;
        logic [CCSR_PCW-1:0] pc;
    } ccsr_core_req_s;

endpackage
